/* File: hdl/irq_regs_pkg.sv */
package irq_regs_pkg;

  // Bus geometry
  localparam int DATA_W      = 32;
  localparam int ADDR_W      = 32;
  localparam int SEL_W       = DATA_W / 8;

  // Source bit positions
  localparam int SRC_TIMER_ONE   = 0;
  localparam int SRC_TIMER_TWO   = 1;
  localparam int SRC_MANAGEMENT  = 2;
  localparam int SRC_BASEBAND    = 3;
  localparam int SRC_SLEEP_TIMER = 4;
  localparam int SRC_SERIAL1     = 5;
  localparam int SRC_SERIAL2     = 6;
  localparam int SRC_SECURITY    = 7;
  localparam int SRC_RADIO_TIMER = 8;
  localparam int SRC_RADIO_TX    = 9;
  localparam int SRC_RADIO_RX    = 10;
  localparam int SRC_CONVERTER   = 11;
  localparam int SRC_EXT_LINE_A  = 12;
  localparam int SRC_EXT_LINE_B  = 13;
  localparam int SRC_EXT_LINE_C  = 14;
  localparam int SRC_EXT_LINE_D  = 15;
  localparam int SRC_DEBUG       = 16;
  localparam int NUM_SOURCES     = SRC_DEBUG + 1;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFF_PEND_SET   = 32'he000e200;
  localparam logic [ADDR_W-1:0] OFF_PEND_CLEAR = 32'he000e280;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE     = 32'he000e300;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 32'he000e380;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK   = 32'he000e384;

  // Reset values
  localparam logic [NUM_SOURCES-1:0] RST_PENDING = 17'h00000;
  localparam logic [NUM_SOURCES-1:0] RST_ACTIVE  = 17'h00000;
  localparam logic [NUM_SOURCES-1:0] RST_STATUS  = 17'h00000;
  localparam logic [NUM_SOURCES-1:0] RST_MASK    = 17'h00000;
  localparam logic [DATA_W-1:0]      RST_RDATA   = 32'h00000000;

  typedef logic [NUM_SOURCES-1:0] src_vec_t;

  // Core handshake: entry into and return from a handler
  typedef struct packed {
    src_vec_t take;
    src_vec_t retire;
  } core_ctl_t;

endpackage

/* File: hdl/irq_pending_active_regs.sv */
`timescale 1ns/1ps
// Operation
// RL1 - A one written to set bit 16 pends the debug source.
// RL2 - Ones written to set bits 12 to 15 pend external lines A to D.
// RL3 - Set bits 11 to 8 pend converter, radio receive, transmit and timer.
// RL4 - Set bits 7 to 4 pend security, serial two, serial one, sleep timer.
// RL5 - Set bits 3 to 0 pend baseband, management, timer two, timer one.
// RL6 - A zero in the set register leaves that source's pending state alone.
// RL7 - A one written to clear bit 16 unpends the debug source.
// RL8 - Ones written to clear bits 12 to 15 unpend external lines A to D.
// RL9 - Clear bits 11 to 8 unpend converter and the three radio sources.
// RL10 - Clear bits 7 to 0 unpend the remaining eight sources.
// RL11 - A zero in the clear register leaves that source's pending state alone.
// RL12 - Active register bits 16 to 8 show debug, lines, converter, radio activity.
// RL13 - Active register bits 7 to 0 show the other sources; all read-only.
// RL14 - Set, clear and active registers read zero after reset.
// RL15 - Bits 31 to 17 read zero; writes to them are ignored.
// RL16 - Reading set or clear register returns the current pending vector.
module irq_pending_active_regs
  import irq_regs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  input  wire src_vec_t          src_event_i,
  input  wire core_ctl_t         core_i,
  output src_vec_t               pending_o,
  output src_vec_t               active_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic              ack_reg;
  logic [DATA_W-1:0] rdata_reg;
  src_vec_t          pend_reg;
  src_vec_t          pend_next;
  src_vec_t          active_reg;
  src_vec_t          active_next;
  src_vec_t          status_reg;
  src_vec_t          status_next;
  src_vec_t          mask_reg;
  src_vec_t          mask_next;
  logic              irq_reg;
  logic [DATA_W-1:0] lane_mask;
  logic [DATA_W-1:0] wr_data;
  src_vec_t          wr_bits;
  src_vec_t          wr_lanes;
  logic              bus_req;
  logic              bus_wr;
  logic              bus_rd;
  logic              hit_set;
  logic              hit_clr;
  logic              hit_act;
  logic              hit_stat;
  logic              hit_mask;
  src_vec_t          set_ones;
  src_vec_t          clr_ones;
  src_vec_t          stat_clr_ones;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Reserved bits must exist above the sources
  if (NUM_SOURCES >= DATA_W) begin : g_chk_fit
    $error("no reserved bits above the sources");
  end

  // Byte enables cover whole bytes only
  if (DATA_W != 8 * SEL_W) begin : g_chk_lanes
    $error("data width is not a whole number of lanes");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Byte lanes expanded to a bit mask
  for (genvar i = 0; i < SEL_W; i++) begin : g_lane
    assign lane_mask[8*i +: 8] = {8{wb_sel_i[i]}};
  end

  // New request only while no answer is out
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr   = bus_req & wb_we_i;
  assign bus_rd   = bus_req & ~wb_we_i;
  assign hit_set  = (wb_adr_i == OFF_PEND_SET);
  assign hit_clr  = (wb_adr_i == OFF_PEND_CLEAR);
  assign hit_act  = (wb_adr_i == OFF_ACTIVE);
  assign hit_stat = (wb_adr_i == OFF_EVT_STATUS);
  assign hit_mask = (wb_adr_i == OFF_EVT_MASK);

  // Upper bits dropped here, so writes above the sources do nothing
  assign wr_data  = wb_dat_i & lane_mask;
  assign wr_bits  = wr_data[NUM_SOURCES-1:0]; // RL15
  assign wr_lanes = lane_mask[NUM_SOURCES-1:0];

  // Write-one strobes per register
  assign set_ones      = (bus_wr && hit_set) ? wr_bits : '0; // RL1 RL2 RL3 RL4 RL5 RL6
  assign clr_ones      = (bus_wr && hit_clr) ? wr_bits : '0; // RL7 RL8 RL9 RL10 RL11
  assign stat_clr_ones = (bus_wr && hit_stat) ? wr_bits : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic, one slice per source

  for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_src
    // Set writes and events win over a clear or a take in the same cycle
    assign pend_next[s]   = set_ones[s] | src_event_i[s]
                            | (pend_reg[s] & ~clr_ones[s] & ~core_i.take[s]); // RL6 RL11
    // Entry to a handler wins over a return on the same source
    assign active_next[s] = core_i.take[s] | (active_reg[s] & ~core_i.retire[s]); // RL12 RL13
    // An event wins over a one-to-clear, so no event is lost
    assign status_next[s] = src_event_i[s] | (status_reg[s] & ~stat_clr_ones[s]);
    // Mask bits change only in the byte lanes selected
    assign mask_next[s]   = (bus_wr && hit_mask && wr_lanes[s]) ? wr_bits[s] : mask_reg[s];

    // Without any cause this source keeps its pending state
    AST_BIT_HOLD: assert property ( // RL6 RL11
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      !(set_ones[s] || src_event_i[s] || clr_ones[s] || core_i.take[s]) |=> $stable(pend_reg[s]))
      else $error("pending bit changed without cause");

    // Without entry or return this source keeps its active state
    AST_BIT_ACT_HOLD: assert property ( // RL13
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      !(core_i.take[s] || core_i.retire[s]) |=> $stable(active_reg[s]))
      else $error("active bit changed without cause");

    // A set write beats a clear or a take on this source
    AST_BIT_SET_WINS: assert property ( // RL1 RL2 RL3 RL4 RL5
      @(posedge clk_i) disable iff (rst_i || !ce_i)
      set_ones[s] |=> pend_reg[s])
      else $error("set write lost on its source");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer

  // One-cycle ack for every request, mapped or not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= bus_req;
    end
  end

  // Read data captured with the ack; unmapped and writes read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= RST_RDATA; // RL14
    end else if (ce_i) begin
      rdata_reg <= RST_RDATA;
      if (bus_rd) begin
        if (hit_set || hit_clr) begin
          rdata_reg <= DATA_W'(pend_reg); // RL16 RL15
        end else if (hit_act) begin
          rdata_reg <= DATA_W'(active_reg); // RL12 RL13 RL15
        end else if (hit_stat) begin
          rdata_reg <= DATA_W'(status_reg);
        end else if (hit_mask) begin
          rdata_reg <= DATA_W'(mask_reg);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending and active state

  // Pending vector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= RST_PENDING; // RL14
    end else if (ce_i) begin
      pend_reg <= pend_next; // RL1 RL2 RL3 RL4 RL5 RL7 RL8 RL9 RL10
    end
  end

  // Active vector, driven only by the core handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= RST_ACTIVE; // RL14
    end else if (ce_i) begin
      active_reg <= active_next; // RL12 RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt line

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= RST_STATUS;
      mask_reg   <= RST_MASK;
      irq_reg    <= 1'b0;
    end else if (ce_i) begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= |(status_next & mask_next); // Tracks the registers exactly
    end
  end

  // Outputs straight from flops
  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = rdata_reg;
  assign pending_o = pend_reg;
  assign active_o  = active_reg;
  assign irq_o     = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_set_wr;
    bus_wr && hit_set;
  endsequence

  sequence s_clr_wr;
    bus_wr && hit_clr;
  endsequence

  sequence s_pend_rd;
    bus_rd && (hit_set || hit_clr);
  endsequence

  sequence s_act_rd;
    bus_rd && hit_act;
  endsequence

  // Written ones are pending afterwards
  AST_SET_PENDS: assert property ( // RL1 RL2 RL3 RL4 RL5
    s_set_wr |=> ((pend_reg & $past(wr_bits)) == $past(wr_bits)))
    else $error("set write did not pend its sources");

  // Cleared ones are gone unless an event hit the same cycle
  AST_CLR_UNPENDS: assert property ( // RL7 RL8 RL9 RL10
    s_clr_wr |=> ((pend_reg & $past(wr_bits & ~src_event_i)) == '0))
    else $error("clear write left sources pending");

  // A pending bit rises only from a set write or an event
  AST_RISE_CAUSED: assert property ( // RL6
    ((pend_reg & ~$past(pend_reg)) & ~$past(set_ones | src_event_i)) == '0)
    else $error("pending bit rose without cause");

  // A pending bit falls only from a clear write or a handler entry
  AST_FALL_CAUSED: assert property ( // RL11
    ((~pend_reg & $past(pend_reg)) & ~$past(clr_ones | core_i.take)) == '0)
    else $error("pending bit fell without cause");

  // An event beats a simultaneous clear
  AST_EVENT_WINS: assert property ( // RL7
    (s_clr_wr and (src_event_i != '0)) |=> ((pend_reg & $past(src_event_i)) == $past(src_event_i)))
    else $error("event lost against clear");

  // Handler entry marks active and unpends
  AST_TAKE_ACTIVE: assert property ( // RL12 RL13
    (core_i.take != '0) |=> (((active_reg & $past(core_i.take)) == $past(core_i.take))
      && ((pend_reg & $past(core_i.take & ~src_event_i & ~set_ones)) == '0)))
    else $error("take did not move source to active");

  // Active register is untouched by bus writes
  AST_ACTIVE_RO: assert property ( // RL13
    (bus_wr && hit_act && core_i.take == '0 && core_i.retire == '0) |=> $stable(active_reg))
    else $error("write changed active register");

  // Pending read returns the vector at the request
  AST_READ_PEND: assert property ( // RL16
    s_pend_rd |=> (wb_ack_o && wb_dat_o == DATA_W'($past(pend_reg))))
    else $error("pending read data wrong");

  // Active read returns the vector at the request
  AST_READ_ACTIVE: assert property ( // RL12
    s_act_rd |=> (wb_ack_o && wb_dat_o == DATA_W'($past(active_reg))))
    else $error("active read data wrong");

  // High bits never read as one
  AST_UPPER_ZERO: assert property ( // RL15
    wb_dat_o[DATA_W-1:NUM_SOURCES] == '0)
    else $error("reserved bits read nonzero");

  // Zero state after reset, regardless of enable
  AST_RESET_ZERO: assert property ( // RL14
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> (pend_reg == '0 && active_reg == '0 && wb_dat_o == '0 && !wb_ack_o
               && status_reg == '0 && mask_reg == '0 && !irq_o))
    else $error("state not zero after reset");

  // Ack is a single-cycle pulse per request
  AST_ACK_PULSE: assert property (
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-cycle pulse");

  // Interrupt line matches unmasked status
  AST_IRQ_LEVEL: assert property (
    irq_o == |(status_reg & mask_reg))
    else $error("interrupt line disagrees with status");

  sequence s_stat_wr;
    bus_wr && hit_stat;
  endsequence

  sequence s_mask_wr;
    bus_wr && hit_mask;
  endsequence

  // Read data is zero outside the ack cycle
  AST_DATA_IDLE_ZERO: assert property (
    !wb_ack_o |-> (wb_dat_o == '0))
    else $error("read data outside the ack cycle");

  // No answer without a request
  AST_ACK_ONLY_REQ: assert property (
    !bus_req |=> !wb_ack_o)
    else $error("ack without request");

  // Writes return zero data in their ack cycle
  AST_WRITE_DATA_ZERO: assert property (
    bus_wr |=> (wb_dat_o == '0))
    else $error("write returned data");

  // Unselected lanes of a set write pend nothing
  AST_LANE_GUARD: assert property ( // RL6
    s_set_wr |=> (((pend_reg & ~$past(pend_reg)) & ~$past(wr_lanes | src_event_i)) == '0))
    else $error("set write reached an unselected lane");

  // Ones written to status clear it unless an event hits
  AST_STATUS_W1C: assert property (
    s_stat_wr |=> ((status_reg & $past(wr_bits & ~src_event_i)) == '0))
    else $error("status bit survived its clear");

  // Status bits fall only by a one written to them
  AST_STATUS_STICKY: assert property (
    ((~status_reg & $past(status_reg)) & ~$past(stat_clr_ones)) == '0)
    else $error("status bit fell without a clear");

  // A mask write leaves the written bits in its lanes
  AST_MASK_WRITE: assert property (
    s_mask_wr |=> ((mask_reg & $past(wr_lanes)) == $past(wr_bits)))
    else $error("mask write did not land");

  // Return clears the active bit unless re-entered
  AST_RETIRE_CLEARS: assert property ( // RL12 RL13
    (core_i.retire != '0) |=> ((active_reg & $past(core_i.retire & ~core_i.take)) == '0))
    else $error("retire left source active");

  // Active bits rise only by a handler entry
  AST_ACTIVE_RISE_CAUSED: assert property ( // RL13
    ((active_reg & ~$past(active_reg)) & ~$past(core_i.take)) == '0)
    else $error("active bit rose without entry");

  // Unmapped writes change no register
  AST_UNMAPPED_INERT: assert property (
    (bus_wr && !(hit_set || hit_clr || hit_act || hit_stat || hit_mask))
      |=> ($stable(mask_reg) && ((pend_reg & ~$past(pend_reg) & ~$past(src_event_i)) == '0)))
    else $error("unmapped write changed state");

  // Line rises with an unmasked event
  AST_IRQ_ON_EVENT: assert property (
    ((src_event_i & mask_next) != '0) |=> irq_o)
    else $error("unmasked event raised no line");

  // Status read returns the vector at the request
  AST_READ_STATUS: assert property (
    (bus_rd && hit_stat) |=> (wb_ack_o && wb_dat_o == DATA_W'($past(status_reg))))
    else $error("status read data wrong");

  // Mask read returns the vector at the request
  AST_READ_MASK: assert property (
    (bus_rd && hit_mask) |=> (wb_ack_o && wb_dat_o == DATA_W'($past(mask_reg))))
    else $error("mask read data wrong");

endmodule

/* File: testbench/core_model.sv */
`timescale 1ns/1ps
module core_model
  import irq_regs_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire src_vec_t pending_i,
  input  wire logic     enter_i,
  input  wire logic     leave_i,
  output core_ctl_t     core_o
);
  src_vec_t held_reg;
  src_vec_t lowest;

  // Lowest pending source
  assign lowest = pending_i & (~pending_i + 1'b1);

  // Enter lowest pending source, return from it on request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_o   <= '0;
      held_reg <= '0;
    end else if (enter_i && (pending_i != '0)) begin
      core_o   <= '{take: lowest, retire: '0};
      held_reg <= lowest;
    end else if (leave_i) begin
      core_o   <= '{take: '0, retire: held_reg};
      held_reg <= '0;
    end else begin
      core_o <= '0;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import irq_regs_pkg::*;
  logic              clk_i    = 1'b0;
  logic              rst_i    = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i  = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [SEL_W-1:0]  wb_sel_i = '0;
  logic [DATA_W-1:0] wb_dat_i = '0;
  logic [DATA_W-1:0] wb_dat_o;
  logic              wb_ack_o;
  src_vec_t          src_event_i = '0;
  core_ctl_t         core_i;
  src_vec_t          pending_o;
  src_vec_t          active_o;
  logic              irq_o;
  logic              enter = 1'b0;
  logic              leave = 1'b0;
  logic              ce = 1'b1;
  int                err_total = 0;
  int                checks_done = 0;
  int                cyc_cnt = 0;

  ////////////////////////////////////////////////////////////
  // Clock and instances
  always #20 clk_i = ~clk_i;

  irq_pending_active_regs u_irq_pending_active_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_event_i(src_event_i),
    .core_i(core_i), .pending_o(pending_o), .active_o(active_o), .irq_o(irq_o));

  core_model u_core_model (.clk_i(clk_i), .rst_i(rst_i), .pending_i(pending_o), .enter_i(enter),
    .leave_i(leave), .core_o(core_i));

  ////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, about five times the expected run
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////
  // Wishbone classic single cycle
  task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] wd, input logic [3:0] sel,
                      output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wrs(input logic [31:0] adr, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] d;
    xfer(1'b1, adr, wd, sel, d);
  endtask

  task automatic wr(input logic [31:0] adr, input logic [31:0] wd);
    wrs(adr, wd, 4'hf);
  endtask

  task automatic rd(input logic [31:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] d;
    xfer(1'b0, adr, 32'h0, 4'hf, d);
    check(what, d, exp);
  endtask

  // One-cycle pulse on the entry or return line, then let it settle
  task automatic pulse(input logic is_leave);
    @(posedge clk_i);
    if (is_leave) begin
      leave <= 1'b1;
    end else begin
      enter <= 1'b1;
    end
    @(posedge clk_i);
    enter <= 1'b0;
    leave <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_PEND_SET, 32'h0, "set_rst");
    rd(OFF_PEND_CLEAR, 32'h0, "clr_rst");
    rd(OFF_ACTIVE, 32'h0, "act_rst");
    for (int i = 0; i < NUM_SOURCES; i++) begin
      wr(OFF_PEND_SET, 32'h1 << i);
      rd(OFF_PEND_SET, 32'h1 << i, "set_walk");
      rd(OFF_PEND_CLEAR, 32'h1 << i, "clr_view");
      check("pend_pin", {15'h0, pending_o}, 32'h1 << i);
      wr(OFF_PEND_CLEAR, 32'h1 << i);
      rd(OFF_PEND_SET, 32'h0, "clr_walk");
    end
    wr(OFF_PEND_SET, 32'h0000a5a5);
    wr(OFF_PEND_SET, 32'h0);
    rd(OFF_PEND_SET, 32'h0000a5a5, "set_zero");
    wr(OFF_PEND_CLEAR, 32'h00000005);
    rd(OFF_PEND_SET, 32'h0000a5a0, "clr_part");
    wr(OFF_PEND_SET, 32'hffffffff);
    rd(OFF_PEND_CLEAR, 32'h0001ffff, "upper");
    wr(OFF_PEND_CLEAR, 32'hffffffff);
    wrs(OFF_PEND_SET, 32'h0001ffff, 4'h4);
    rd(OFF_PEND_SET, 32'h00010000, "lane");
    wr(OFF_ACTIVE, 32'hffffffff);
    rd(OFF_ACTIVE, 32'h0, "act_ro");
    // Core enters two handlers in turn
    wr(OFF_PEND_SET, 32'h00000008);
    pulse(1'b0);
    check("act_pin", {15'h0, active_o}, 32'h00000008);
    rd(OFF_ACTIVE, 32'h00000008, "act_low");
    rd(OFF_PEND_SET, 32'h00010000, "take_clr");
    pulse(1'b1);
    rd(OFF_ACTIVE, 32'h0, "retire");
    pulse(1'b0);
    check("act_pin_hi", {15'h0, active_o}, 32'h00010000);
    rd(OFF_ACTIVE, 32'h00010000, "act_high");
    pulse(1'b1);
    rd(32'he000e204, 32'h0, "unmapped");
    wr(32'he000e204, 32'hffffffff);
    rd(OFF_PEND_SET, 32'h0, "unm_wr");
    // Event status, mask and interrupt line
    src_event_i <= 17'h01020;
    @(posedge clk_i);
    src_event_i <= '0;
    rd(OFF_EVT_STATUS, 32'h00001020, "status");
    check("irq_masked", {31'h0, irq_o}, 32'h0);
    wr(OFF_EVT_MASK, 32'h00000020);
    check("irq_on", {31'h0, irq_o}, 32'h1);
    wr(OFF_EVT_STATUS, 32'h00000020);
    check("irq_off", {31'h0, irq_o}, 32'h0);
    rd(OFF_EVT_STATUS, 32'h00001000, "w1c");
    rd(OFF_PEND_SET, 32'h00001020, "evt_pend");
    // Event and clear write taken at one edge: the event stays
    fork
      wr(OFF_PEND_CLEAR, 32'h00000020);
      begin
        @(posedge clk_i);
        src_event_i <= 17'h00020;
        @(posedge clk_i);
        src_event_i <= '0;
      end
    join
    rd(OFF_PEND_SET, 32'h00001020, "evt_beats_clr");
    check("irq_again", {31'h0, irq_o}, 32'h1);
    // Clock enable low: an event is not taken
    @(posedge clk_i);
    ce <= 1'b0;
    src_event_i <= 17'h00001;
    @(posedge clk_i);
    src_event_i <= '0;
    @(posedge clk_i);
    ce <= 1'b1;
    rd(OFF_PEND_SET, 32'h00001020, "ce_hold");
    rd(OFF_EVT_STATUS, 32'h00001020, "ce_stat");
    // Reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_PEND_SET, 32'h0, "rerst");
    rd(OFF_ACTIVE, 32'h0, "act_rerst");
    rd(OFF_EVT_STATUS, 32'h0, "stat_rerst");
    check("irq_rerst", {31'h0, irq_o}, 32'h0);
    summarize();
  end
endmodule
